// [hdl/qdi_slave.sv]
// Two-wire serial slave front end of a quad voltage-output converter.
// Assumes a 100 MHz clk_i, pins from outside the domain, open-drain SDA
// resolved outside, and converter-side logic on the same clock.
//
// Implementation choices: register access over Wishbone and the register offsets.
`default_nettype none

module qdi_slave
  import qdi_pkg::*;
#(
  // Device type code; arbitrary value
  parameter logic [3:0] DEV_TYPE = 4'ha
)
(
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Serial pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic output_latch_strobe_i,
  // Converter side
  input wire logic [7:0] rd_data_i,
  output logic rd_next_o,
  output logic nv_reload_o,
  output logic update_now_o,
  output logic update_all_o,
  output logic powerdown_clear_o,
  output logic hs_mode_o,
  output logic [2:0] addr_bits_o,
  output logic [2:0] nv_addr_o
);

  // ----------------------------------------------------------------
  // Pin capture and bus conditions
  // ----------------------------------------------------------------
  logic [2:0] pins_s;
  qdi_bus_s bus;

  qdi_sync #(.W(3)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({output_latch_strobe_i, sda_i, scl_i}),
    .q_o(pins_s)
  );

  qdi_cond u_cond (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pins_i(pins_s),
    .bus_o(bus)
  );

  // ----------------------------------------------------------------
  // Byte engine
  // ----------------------------------------------------------------
  qdi_state_e state;
  qdi_state_e pend_state;
  qdi_state_e next_state;
  logic [3:0] cnt;
  logic [1:0] byte_no;
  logic [7:0] rx;
  logic [7:0] tx;
  logic [7:0] next_tx;
  logic ack_now;
  logic ra_pending;
  logic ra_sel;
  logic aw_armed;
  logic [1:0] ctrl;
  logic fall_last;
  logic fall_ack;
  logic active;
  logic gc_hit;
  logic aw_commit;
  logic wb_req;
  logic wb_wr;
  qdi_evt_s evt;
  qdi_evt_s evt_set;

  assign active = (state == QDI_S_ADDR) || (state == QDI_S_GC) ||
                  (state == QDI_S_WR) || (state == QDI_S_TX);
  assign fall_last = active && bus.scl_fall && (cnt == QDI_LAST_BIT);
  assign fall_ack = active && bus.scl_fall && (cnt == QDI_ACK_CNT);
  assign gc_hit = fall_ack && (state == QDI_S_GC);
  assign aw_commit = fall_ack && (state == QDI_S_WR) && aw_armed &&
                     (byte_no == QDI_AW_NEW_BYTE) &&
                     (rx[7:5] == QDI_CMD_ADDR_WR);
  // Report byte: stored bits, marker, working bits, marker
  assign next_tx = ra_pending ? {nv_addr_o, 1'b1, addr_bits_o, 1'b0}
                              : rd_data_i;

  // Ack decision for the byte just completed
  always_comb
  begin
    ack_now = 1'b0;
    next_state = QDI_S_IGNORE;
    case (state)
      QDI_S_ADDR:
      begin
        if (rx == QDI_GC_ADDR && ctrl[QDI_CTRL_GC_EN])
        begin
          ack_now = 1'b1;
          next_state = QDI_S_GC;
        end
        else if (ra_pending && rx[7:4] == DEV_TYPE && rx[0] &&
                 !bus.strobe)
        begin
          ack_now = 1'b1;
          next_state = QDI_S_TX;
        end
        else if (rx[7:4] == DEV_TYPE && rx[3:1] == addr_bits_o &&
                 ctrl[QDI_CTRL_EN])
        begin
          ack_now = 1'b1;
          next_state = rx[0] ? QDI_S_TX : QDI_S_WR;
        end
      end
      QDI_S_GC:
      begin
        ack_now = (rx == QDI_GC_RESET) || (rx == QDI_GC_WAKE) ||
                  (rx == QDI_GC_SWUPD) ||
                  (rx == QDI_GC_RDADDR && ra_sel);
      end
      QDI_S_WR:
      begin
        ack_now = 1'b1;
        next_state = QDI_S_WR;
      end
      default:
      begin
        ack_now = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= QDI_S_IDLE;
      pend_state <= QDI_S_IDLE;
      cnt <= '0;
      byte_no <= '0;
      rx <= '0;
      tx <= '0;
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
      rd_next_o <= 1'b0;
    end
    else
    begin
      rd_next_o <= 1'b0;
      if (bus.stop)
      begin
        state <= QDI_S_IDLE;
        sda_oe_o <= 1'b0;
      end
      else if (bus.start)
      begin
        state <= QDI_S_ADDR;
        // The start's own clock fall wraps this to zero, not a bit
        cnt <= '1;
        byte_no <= '0;
        sda_oe_o <= 1'b0;
      end
      else if (active && bus.scl_rise)
      begin
        if (cnt != QDI_ACK_CNT)
        begin
          rx <= {rx[6:0], bus.sda};
        end
        else if (state == QDI_S_TX && bus.sda)
        begin
          state <= QDI_S_IGNORE;
        end
      end
      else if (fall_last)
      begin
        cnt <= QDI_ACK_CNT;
        if (state == QDI_S_TX)
        begin
          sda_oe_o <= 1'b0;
        end
        else if (ack_now)
        begin
          sda_oe_o <= 1'b1;
          pend_state <= next_state;
        end
        else
        begin
          state <= QDI_S_IGNORE;
          sda_oe_o <= 1'b0;
        end
      end
      else if (fall_ack)
      begin
        cnt <= '0;
        if (byte_no != 2'h3)
        begin
          byte_no <= byte_no + 2'h1;
        end
        if (state == QDI_S_TX || pend_state == QDI_S_TX)
        begin
          state <= QDI_S_TX;
          tx <= next_tx;
          sda_oe_o <= !next_tx[7];
          rd_next_o <= !ra_pending;
        end
        else
        begin
          state <= pend_state;
          sda_oe_o <= 1'b0;
        end
      end
      else if (active && bus.scl_fall)
      begin
        cnt <= cnt + 4'h1;
        if (state == QDI_S_TX)
        begin
          tx <= {tx[6:0], 1'b0};
          sda_oe_o <= !tx[6];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Speed mode, read-address selection, address write
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hs_mode_o <= 1'b0;
    end
    else if (bus.stop)
    begin
      hs_mode_o <= 1'b0;
    end
    else if (fall_last && state == QDI_S_ADDR &&
             rx[7:3] == QDI_HS_PREFIX)
    begin
      hs_mode_o <= 1'b1;
    end
  end

  // The strobe must fall in the low phase before the eighth rising edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i || bus.stop)
    begin
      ra_pending <= 1'b0;
      ra_sel <= 1'b0;
    end
    else if (bus.start)
    begin
      ra_sel <= 1'b0;
    end
    else if (state == QDI_S_GC && cnt == QDI_LAST_BIT && !bus.scl &&
             bus.strobe_fall)
    begin
      ra_sel <= 1'b1;
    end
    else if (gc_hit)
    begin
      ra_pending <= (rx == QDI_GC_RDADDR);
    end
    else if (fall_ack && state == QDI_S_TX)
    begin
      ra_pending <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || bus.start)
    begin
      aw_armed <= 1'b0;
    end
    else if (fall_ack && state == QDI_S_WR && byte_no == 2'h1)
    begin
      aw_armed <= (rx[7:5] == QDI_CMD_ADDR_WR) &&
                  (rx[4:2] == addr_bits_o);
    end
  end

  // Stored bits stand in for the non-volatile cells
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      nv_addr_o <= QDI_NV_ADDR_RESET;
      addr_bits_o <= QDI_NV_ADDR_RESET;
    end
    else if (aw_commit)
    begin
      nv_addr_o <= rx[4:2];
      addr_bits_o <= rx[4:2];
    end
    else if (gc_hit && rx == QDI_GC_RESET)
    begin
      addr_bits_o <= nv_addr_o;
    end
    else if (wb_wr && wb_adr_i == QDI_OFS_NVADDR && wb_sel_i[0])
    begin
      nv_addr_o <= wb_dat_i[2:0];
    end
  end

  // ----------------------------------------------------------------
  // General call actions, fired when the ack slot ends
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      nv_reload_o <= 1'b0;
      update_now_o <= 1'b0;
      update_all_o <= 1'b0;
      powerdown_clear_o <= 1'b0;
    end
    else
    begin
      nv_reload_o <= gc_hit && rx == QDI_GC_RESET;
      update_now_o <= gc_hit && rx == QDI_GC_RESET;
      update_all_o <= gc_hit && rx == QDI_GC_SWUPD;
      powerdown_clear_o <= gc_hit && rx == QDI_GC_WAKE;
    end
  end

  // ----------------------------------------------------------------
  // Wishbone registers
  // ----------------------------------------------------------------
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i;

  always_comb
  begin
    evt_set.reset = gc_hit && rx == QDI_GC_RESET;
    evt_set.wake = gc_hit && rx == QDI_GC_WAKE;
    evt_set.swupd = gc_hit && rx == QDI_GC_SWUPD;
    evt_set.rd_addr = gc_hit && rx == QDI_GC_RDADDR;
    evt_set.addr_wr = aw_commit;
  end

  // A new event beats a clear in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      evt <= '0;
    end
    else if (wb_wr && wb_adr_i == QDI_OFS_EVENT && wb_sel_i[0])
    begin
      evt <= (evt & ~qdi_evt_s'(wb_dat_i[4:0])) | evt_set;
    end
    else
    begin
      evt <= evt | evt_set;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl <= QDI_CTRL_RESET;
    end
    else if (wb_wr && wb_adr_i == QDI_OFS_CTRL && wb_sel_i[0])
    begin
      ctrl <= wb_dat_i[1:0];
    end
  end

  // Unmapped offsets read zero and still answer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= '0;
      if (wb_req && !wb_we_i)
      begin
        case (wb_adr_i)
          QDI_OFS_CTRL: wb_dat_o <= {30'h0, ctrl};
          QDI_OFS_STATUS: wb_dat_o <= {23'h0, bus.idle, active,
                                       hs_mode_o, addr_bits_o,
                                       nv_addr_o};
          QDI_OFS_EVENT: wb_dat_o <= {27'h0, evt};
          QDI_OFS_NVADDR: wb_dat_o <= {29'h0, nv_addr_o};
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_hs_no_ack: assert property ($rose(hs_mode_o) |-> !sda_oe_o)
    else $error("high-speed code byte was acknowledged");
  a_hs_stop_exit: assert property (bus.stop |=> !hs_mode_o)
    else $error("high-speed mode kept after stop");
  a_start_rearm: assert property (bus.start && !bus.stop |=>
    state == QDI_S_ADDR && cnt == 4'hf && !sda_oe_o)
    else $error("start did not rearm the address byte");
  a_stop_release: assert property (bus.stop |=>
    state == QDI_S_IDLE && !sda_oe_o)
    else $error("stop did not release the bus");
  a_drive_clk_low: assert property ($rose(sda_oe_o) |-> !bus.scl)
    else $error("data driven while clock high");
  a_ack_slot_held: assert property (fall_last && ack_now &&
    state != QDI_S_TX |=> sda_oe_o throughout
    (cnt == QDI_ACK_CNT && !bus.scl_fall)[*2])
    else $error("acknowledge not held low");
  a_nack_release: assert property (state == QDI_S_TX && bus.scl_rise &&
    cnt == QDI_ACK_CNT && bus.sda && !bus.stop && !bus.start |=>
    state == QDI_S_IGNORE && !sda_oe_o)
    else $error("line not released after master nack");
  a_foreign_quiet: assert property (state == QDI_S_IGNORE |->
    !sda_oe_o)
    else $error("ignored transfer drives data");
  a_gc_reload: assert property (nv_reload_o |->
    update_now_o && addr_bits_o == nv_addr_o)
    else $error("general call reset incomplete");
  a_wake_cause: assert property (powerdown_clear_o |->
    $past(rx) == QDI_GC_WAKE && !nv_reload_o)
    else $error("wake-up without wake-up command");

  c_hs_entry: cover property ($rose(hs_mode_o));
  c_gc_reset: cover property (nv_reload_o);
  c_read_byte: cover property (rd_next_o);
  c_addr_write: cover property (aw_commit);

endmodule

`default_nettype wire

// [shared/qdi_pkg.sv]
// Constants, states and carriers of the two-wire converter slave.
// Assumes a single 100 MHz system clock oversampling the bus pins.
`default_nettype none

package qdi_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] QDI_OFS_CTRL = 4'h0;
  localparam logic [3:0] QDI_OFS_STATUS = 4'h4;
  localparam logic [3:0] QDI_OFS_EVENT = 4'h8;
  localparam logic [3:0] QDI_OFS_NVADDR = 4'hc;
  localparam int QDI_CTRL_EN = 0;
  localparam int QDI_CTRL_GC_EN = 1;
  localparam logic [1:0] QDI_CTRL_RESET = 2'h3;
  localparam logic [2:0] QDI_NV_ADDR_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Serial protocol values
  // ----------------------------------------------------------------
  localparam logic [7:0] QDI_GC_ADDR = 8'h00;
  localparam logic [7:0] QDI_GC_RESET = 8'h06;
  localparam logic [7:0] QDI_GC_WAKE = 8'h09;
  localparam logic [7:0] QDI_GC_SWUPD = 8'h08;
  localparam logic [7:0] QDI_GC_RDADDR = 8'h0c;
  localparam logic [4:0] QDI_HS_PREFIX = 5'h01;
  localparam logic [2:0] QDI_CMD_ADDR_WR = 3'h3;
  localparam logic [3:0] QDI_LAST_BIT = 4'h7;
  localparam logic [3:0] QDI_ACK_CNT = 4'h8;
  localparam logic [1:0] QDI_AW_NEW_BYTE = 2'h2;

  typedef enum logic [5:0] {
    QDI_S_IDLE = 6'h01,
    QDI_S_ADDR = 6'h02,
    QDI_S_GC = 6'h04,
    QDI_S_WR = 6'h08,
    QDI_S_TX = 6'h10,
    QDI_S_IGNORE = 6'h20
  } qdi_state_e;

  typedef struct packed {
    logic strobe;
    logic strobe_fall;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic idle;
  } qdi_bus_s;

  typedef struct packed {
    logic rd_addr;
    logic addr_wr;
    logic swupd;
    logic wake;
    logic reset;
  } qdi_evt_s;

endpackage

`default_nettype wire

// [hdl/qdi_sync.sv]
// Two-stage synchroniser for asynchronous pin levels.
// Assumes the pins idle high, so both stages reset to ones.
`default_nettype none

module qdi_sync
#(
  parameter int W = 3
)
(
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta <= '1;
      q_o <= '1;
    end
    else
    begin
      meta <= d_i;
      q_o <= meta;
    end
  end

endmodule

`default_nettype wire

// [hdl/qdi_cond.sv]
// Bus condition decoder: clock edges, start, stop and idle.
// Assumes its inputs are already synchronised to clk_i.
`default_nettype none

module qdi_cond
  import qdi_pkg::*;
(
  // System
  input wire logic clk_i,
  input wire logic rst_i,
  // Synchronised pins: {strobe, sda, scl}
  input wire logic [2:0] pins_i,
  // Decoded conditions
  output qdi_bus_s bus_o
);

  logic scl_q;
  logic sda_q;
  logic stb_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      stb_q <= 1'b1;
    end
    else
    begin
      scl_q <= pins_i[0];
      sda_q <= pins_i[1];
      stb_q <= pins_i[2];
    end
  end

  always_comb
  begin
    bus_o.scl = pins_i[0];
    bus_o.sda = pins_i[1];
    bus_o.strobe = pins_i[2];
    bus_o.strobe_fall = stb_q && !pins_i[2];
    bus_o.scl_rise = pins_i[0] && !scl_q;
    bus_o.scl_fall = !pins_i[0] && scl_q;
    bus_o.start = scl_q && pins_i[0] && sda_q && !pins_i[1];
    bus_o.stop = scl_q && pins_i[0] && !sda_q && pins_i[1];
    bus_o.idle = pins_i[0] && pins_i[1];
  end

endmodule

`default_nettype wire

// [test/qdi_master_model.sv]
// Behavioural two-wire bus master: drives SCL and pulls SDA low.
// Assumes the bench resolves SDA with a pull-up from all pull-downs.
`default_nettype none

module qdi_master_model
(
  // System
  input wire logic clk_i,
  // Bus
  output logic scl_o,
  output logic sda_oe_o,
  input wire logic sda_i
);
  timeunit 1ns;
  timeprecision 1ps;

  // Half an SCL period in clk cycles; 4 gives an 80 ns period
  int ph = 4;

  initial
  begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Only called with the bus idle
  task automatic start_c();
    tick(ph);
    sda_oe_o <= 1'b1;
    tick(ph);
    scl_o <= 1'b0;
  endtask

  // Repeated start from the low phase after an acknowledge
  task automatic rstart_c();
    tick(ph / 2);
    sda_oe_o <= 1'b0;
    tick(ph / 2);
    scl_o <= 1'b1;
    start_c();
  endtask

  task automatic stop_c();
    tick(ph / 2);
    sda_oe_o <= 1'b1;
    tick(ph / 2);
    scl_o <= 1'b1;
    tick(ph);
    sda_oe_o <= 1'b0;
    tick(ph);
  endtask

  // Data moves mid-low, sampled mid-high
  task automatic bit_c(input logic b, output logic s);
    tick(ph / 2);
    sda_oe_o <= ~b;
    tick(ph / 2);
    scl_o <= 1'b1;
    tick(ph / 2);
    s = sda_i;
    tick(ph / 2);
    scl_o <= 1'b0;
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_c(d[i], s);
    bit_c(1'b1, ack);
  endtask

  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_c(1'b1, d[i]);
    bit_c(last, s);
  endtask
endmodule

`default_nettype wire

// [test/qdi_slave_test.sv]
// Self-checking bench of the two-wire converter slave.
// Assumes the master model and the Wishbone tasks start on a clk edge.
`default_nettype none

module qdi_slave_test
  import qdi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // Device type code; arbitrary value
  localparam logic [3:0] DEV = 4'h5;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [3:0] wb_adr = 4'h0;
  logic [31:0] wb_wdat = 32'h0;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic [7:0] rd_data = 8'ha5;
  logic output_latch_strobe = 1'b1;
  logic sda_val;
  logic scl, m_oe, sda_oe, rd_next, nv_rel, upd_now, upd_all, pd_clr;
  logic hs_mode;
  logic [2:0] addr_bits, nv_addr;
  wire logic sda;
  int failures = 0;
  int total_checks = 0;
  int n_rel = 0, n_now = 0, n_all = 0, n_pd = 0, n_rdn = 0;

  // Pull-up: the line is high unless someone pulls it
  assign sda = ~(m_oe | sda_oe);

  always #5 clk = ~clk;

  always @(posedge clk)
  begin
    n_rel += int'(nv_rel === 1'b1);
    n_now += int'(upd_now === 1'b1);
    n_all += int'(upd_all === 1'b1);
    n_pd += int'(pd_clr === 1'b1);
    n_rdn += int'(rd_next === 1'b1);
  end

  qdi_slave #(.DEV_TYPE(DEV)) dut (.clk_i(clk), .rst_i(rst),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_val), .sda_oe_o(sda_oe),
    .output_latch_strobe_i(output_latch_strobe),
    .rd_data_i(rd_data), .rd_next_o(rd_next), .nv_reload_o(nv_rel),
    .update_now_o(upd_now), .update_all_o(upd_all),
    .powerdown_clear_o(pd_clr), .hs_mode_o(hs_mode),
    .addr_bits_o(addr_bits), .nv_addr_o(nv_addr));

  qdi_master_model mst (.clk_i(clk), .scl_o(scl), .sda_oe_o(m_oe),
    .sda_i(sda));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wb(input logic we, input logic [3:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdat <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack !== 1'b1 && n < 20);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk);
    if (n >= 20)
    begin
      failures++;
      close_out();
    end
  endtask

  task automatic wbr(input logic [3:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0, q);
  endtask

  task automatic wbw(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  // Whole framed one-byte write, returning the acknowledge level
  task automatic one_byte(input logic [7:0] b, output logic a);
    mst.start_c();
    mst.wr_byte(b, a);
    mst.stop_c();
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] q;
    wbr(QDI_OFS_CTRL, q);
    chk("ctrl", q, {30'h0, QDI_CTRL_RESET});
    wbr(QDI_OFS_NVADDR, q);
    chk("nvaddr", q, 32'h0);
    wbw(4'h6, 32'h7);
    wbr(4'h6, q);
    chk("unmapped", q, 32'h0);
    wbr(QDI_OFS_STATUS, q);
    chk("status", q, 32'h100);
    $display("test reset done");
  endtask

  task automatic t_write();
    logic a;
    logic [31:0] q;
    mst.start_c();
    mst.wr_byte({DEV, 3'h0, 1'b0}, a);
    chk("addr ack", a, 1'b0);
    mst.wr_byte(8'h40, a);
    chk("cmd ack", a, 1'b0);
    mst.stop_c();
    one_byte({DEV, 3'h1, 1'b0}, a);
    chk("foreign", a, 1'b1);
    wbr(QDI_OFS_STATUS, q);
    chk("idle", q, 32'h100);
    $display("test write done");
  endtask

  task automatic t_gc();
    logic a;
    logic [31:0] q;
    logic [7:0] codes [3] = '{QDI_GC_RESET, QDI_GC_WAKE, QDI_GC_SWUPD};
    for (int i = 0; i < 3; i++)
    begin
      mst.start_c();
      mst.wr_byte(QDI_GC_ADDR, a);
      chk("gc ack", a, 1'b0);
      mst.wr_byte(codes[i], a);
      chk("gc cmd ack", a, 1'b0);
      mst.stop_c();
      wbr(QDI_OFS_EVENT, q);
      chk("event", q, 32'h1 << i);
      wbw(QDI_OFS_EVENT, 32'h1 << i);
      wbr(QDI_OFS_EVENT, q);
      chk("event clr", q, 32'h0);
    end
    chk("reload", 32'(n_rel), 32'h1);
    chk("update now", 32'(n_now), 32'h1);
    chk("pd clear", 32'(n_pd), 32'h1);
    chk("update all", 32'(n_all), 32'h1);
    $display("test general call done");
  endtask

  task automatic t_hs();
    logic a;
    mst.start_c();
    mst.wr_byte({QDI_HS_PREFIX, 3'h5}, a);
    chk("hs nack", a, 1'b1);
    chk("hs on", hs_mode, 1'b1);
    mst.stop_c();
    chk("hs off", hs_mode, 1'b0);
    $display("test high speed done");
  endtask

  task automatic t_read();
    logic a;
    logic [7:0] d;
    mst.start_c();
    mst.wr_byte({DEV, 3'h0, 1'b1}, a);
    chk("rd addr ack", a, 1'b0);
    mst.rd_byte(1'b1, d);
    chk("rd byte", d, rd_data);
    chk("released", sda_oe, 1'b0);
    chk("sda value", sda_val, 1'b0);
    mst.stop_c();
    chk("line high", sda, 1'b1);
    chk("rd next", 32'(n_rdn), 32'h1);
    $display("test read done");
  endtask

  task automatic t_addr_wr();
    logic a;
    mst.start_c();
    mst.wr_byte({DEV, 3'h0, 1'b0}, a);
    chk("aw addr", a, 1'b0);
    mst.wr_byte({QDI_CMD_ADDR_WR, 3'h0, 2'h0}, a);
    chk("aw old", a, 1'b0);
    mst.wr_byte({QDI_CMD_ADDR_WR, 3'h5, 2'h0}, a);
    chk("aw new", a, 1'b0);
    mst.stop_c();
    chk("work addr", addr_bits, 3'h5);
    chk("nv addr", nv_addr, 3'h5);
    one_byte({DEV, 3'h5, 1'b0}, a);
    chk("new answers", a, 1'b0);
    one_byte({DEV, 3'h0, 1'b0}, a);
    chk("old ignored", a, 1'b1);
    $display("test address write done");
  endtask

  // Runs after the address write, so both address sets read 5
  task automatic t_rdaddr();
    logic a;
    logic s;
    logic [7:0] d;
    mst.ph = 128;
    mst.start_c();
    mst.wr_byte(QDI_GC_ADDR, a);
    mst.wr_byte(QDI_GC_RDADDR, a);
    chk("ra unselected", a, 1'b1);
    mst.stop_c();
    mst.start_c();
    mst.wr_byte(QDI_GC_ADDR, a);
    chk("ra gc ack", a, 1'b0);
    for (int i = 7; i >= 1; i--)
      mst.bit_c(QDI_GC_RDADDR[i], s);
    mst.tick(mst.ph / 4);
    output_latch_strobe <= 1'b0;
    mst.bit_c(QDI_GC_RDADDR[0], s);
    mst.bit_c(1'b1, a);
    chk("ra cmd ack", a, 1'b0);
    mst.rstart_c();
    mst.wr_byte({DEV, 3'h2, 1'b1}, a);
    output_latch_strobe <= 1'b1;
    chk("ra sel ack", a, 1'b0);
    mst.rd_byte(1'b1, d);
    chk("ra report", d, {3'h5, 1'b1, 3'h5, 1'b0});
    mst.stop_c();
    chk("ra no pop", 32'(n_rdn), 32'h1);
    mst.ph = 4;
    $display("test read address done");
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset();
    t_write();
    t_gc();
    t_hs();
    t_read();
    t_addr_wr();
    t_rdaddr();
    close_out();
  end
endmodule

`default_nettype wire
